// >>> hdl/lmo_pkg.sv
/*
  lmo_pkg: constants shared by the loop multiplexer output section and its
  serial checksum helper. Assumes a 100 MHz core clock.
*/
package lmo_pkg;
  // cell geometry: 12-bit loop cells, first received bit sits in the msb
  localparam int CELL_W = 12;
  localparam int BYTE_W = 11;
  localparam int DATA_W = 8;
  localparam int IDX_W = 4;
  localparam int MARK_POS = 11;
  localparam int ID_HI = 10;
  localparam int ID_LO = 8;
  localparam logic [IDX_W-1:0] LAST_IDX = 4'hb;
  localparam logic [IDX_W-1:0] ID_DONE_IDX = 4'h3; // idx of 4th arriving bit
  localparam logic [IDX_W-1:0] CRC_STOP_IDX = 4'h4;
  // identification codes held in the id field
  localparam logic [2:0] ID_EMPTY = 3'h0;
  localparam logic [2:0] ID_ADDR = 3'h1;
  localparam logic [2:0] ID_DATA = 3'h2;
  localparam logic [2:0] ID_CHKSUM = 3'h3;
  localparam logic [2:0] ID_NULL = 3'h4;
  localparam logic [2:0] ID_LOOP_END = 3'h5;
  // empty cell bit pattern: marker set, empty id, zero data
  localparam logic [CELL_W-1:0] EMPTY_CELL = 12'h800;
  // frame limits
  localparam logic [4:0] MAX_CELLS = 5'h10;
  // generator x^8+x^7+x^6+x+1, x^8 term implied
  localparam logic [DATA_W-1:0] CRC_POLY = 8'hc3;
  localparam logic [DATA_W-1:0] CRC_INIT = 8'h00;
  // regenerated link clock low time after each launched bit
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_LO_NS = 40;
  localparam int CLK_LO_CYC = (CLK_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> hdl/lmo_crc8.sv
/*
  lmo_crc8: serial modulo-2 divider for the frame checksum.
  Assumes one bit strobe at most per clock, all inputs on mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lmo_crc8
  import lmo_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // serial bit feed
  input wire logic step_i,
  input wire logic restart_i,
  input wire logic bit_i,
  // parallel preset
  input wire logic load_i,
  input wire logic [DATA_W-1:0] load_val_i,
  // remainder
  output logic [DATA_W-1:0] crc_o
);
  logic [DATA_W-1:0] base;
  logic fb;

  // restart divides the current bit from a clean remainder
  assign base = restart_i ? CRC_INIT : crc_o;
  assign fb = bit_i ^ base[DATA_W-1];

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      crc_o <= CRC_INIT;
    end else if (load_i) begin
      crc_o <= load_val_i;
    end else if (step_i) begin
      crc_o <= {base[DATA_W-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
    end
  end
endmodule // lmo_crc8
`default_nettype wire

// >>> hdl/lmo_output_section.sv
/*
  lmo_output_section: output section of a serial loop multiplexer with the
  input-section byte overrun guard. Loop clock and data come from the previous
  element as plain pins; line adapters and the input sequencer share mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lmo_output_section
  import lmo_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // incoming loop
  input wire logic loop_clk_i,
  input wire logic loop_data_i,
  // outgoing loop
  output logic loop_clk_o,
  output logic loop_data_o,
  // line adapter select bus
  output logic [DATA_W-1:0] sel_addr_o,
  output logic sel_strobe_o,
  output logic selected_o,
  output logic [BYTE_W-1:0] byte_o,
  output logic byte_valid_o,
  output logic chk_ok_o,
  output logic chk_err_o,
  output logic ovr_err_o,
  output logic deselect_o,
  output logic synced_o,
  // input-side byte guard
  input wire logic in_sel_i,
  input wire logic in_byte_valid_i,
  output logic in_disconnect_o,
  output logic in_append_crc_o
);
  typedef enum logic [1:0] {ST_UNSYNC, ST_HUNT, ST_XFER, ST_DESEL} lmo_state_t;
  lmo_state_t state_r;
  logic clk_s1_r, clk_s2_r, clk_s3_r, dat_s1_r, dat_s2_r;
  logic rx_rise;
  logic [CELL_W-1:0] shreg_r;
  logic [CELL_W-1:0] shreg_nxt;
  logic [IDX_W-1:0] idx_r;
  logic [2:0] id_lat_r;
  logic cell_rdy_r;
  logic [4:0] cell_cnt_r;
  logic [2:0] lo_cnt_r;
  logic [4:0] in_cnt_r;
  logic [DATA_W-1:0] cell_crc, frame_crc;
  logic frame_step, frame_load;
  logic [2:0] cell_id;

  // two-flop sampling of the link pins; stage one feeds only stage two
  // clock stages reset to the idle-high pin level so release gives no false rise
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      clk_s3_r <= 1'b1;
      dat_s1_r <= 1'b0;
      dat_s2_r <= 1'b0;
    end else begin
      clk_s1_r <= loop_clk_i;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      dat_s1_r <= loop_data_i;
      dat_s2_r <= dat_s1_r;
    end
  end

  assign rx_rise = clk_s2_r & ~clk_s3_r;
  assign shreg_nxt = {shreg_r[CELL_W-2:0], dat_s2_r};
  assign cell_id = shreg_r[ID_HI:ID_LO];

  // forward every bit untouched, independent of sync
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      loop_data_o <= 1'b0;
    end else if (rx_rise) begin
      loop_data_o <= dat_s2_r;
    end
  end

  // rebuild clock: low while data settles, then a clean rising edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      loop_clk_o <= 1'b1;
      lo_cnt_r <= 3'h0;
    end else if (rx_rise) begin
      loop_clk_o <= 1'b0;
      lo_cnt_r <= 3'(CLK_LO_CYC - 1);
    end else if (!loop_clk_o) begin
      if (lo_cnt_r == 3'h0) begin
        loop_clk_o <= 1'b1;
      end else begin
        lo_cnt_r <= lo_cnt_r - 3'h1;
      end
    end
  end

  // bit position inside the cell; a full cell raises cell_rdy next cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      shreg_r <= '0;
      idx_r <= '0;
      id_lat_r <= ID_EMPTY;
      cell_rdy_r <= 1'b0;
    end else begin
      cell_rdy_r <= 1'b0;
      if (rx_rise) begin
        shreg_r <= shreg_nxt;
        // pattern test at every bit time while unsynchronised
        if (state_r == ST_UNSYNC) begin
          idx_r <= '0;
        end else if (idx_r == LAST_IDX) begin
          idx_r <= '0;
          cell_rdy_r <= 1'b1;
        end else begin
          idx_r <= idx_r + 4'h1;
        end
        if (idx_r == ID_DONE_IDX) begin
          id_lat_r <= shreg_nxt[2:0];
        end
      end
    end
  end

  // frame checksum stops after the fourth bit of the checksum cell
  assign frame_step = rx_rise && (state_r == ST_XFER) &&
                      !(idx_r >= CRC_STOP_IDX && id_lat_r == ID_CHKSUM);
  // the frame's first bit is in the address cell, so seed from its own remainder
  assign frame_load = cell_rdy_r && (state_r == ST_HUNT) && (cell_id == ID_ADDR);

  lmo_crc8 u_cell_crc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .step_i(rx_rise),
    .restart_i(idx_r == 4'h0),
    .bit_i(dat_s2_r),
    .load_i(1'b0),
    .load_val_i(CRC_INIT),
    .crc_o(cell_crc)
  );

  lmo_crc8 u_frame_crc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .step_i(frame_step),
    .restart_i(1'b0),
    .bit_i(dat_s2_r),
    .load_i(frame_load),
    .load_val_i(cell_crc),
    .crc_o(frame_crc)
  );

  // frame sequencer and adapter bus; pulses last one cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_UNSYNC;
      selected_o <= 1'b0;
      sel_addr_o <= '0;
      sel_strobe_o <= 1'b0;
      byte_o <= '0;
      byte_valid_o <= 1'b0;
      chk_ok_o <= 1'b0;
      chk_err_o <= 1'b0;
      ovr_err_o <= 1'b0;
      deselect_o <= 1'b0;
      cell_cnt_r <= '0;
    end else begin
      sel_strobe_o <= 1'b0;
      byte_valid_o <= 1'b0;
      chk_ok_o <= 1'b0;
      chk_err_o <= 1'b0;
      ovr_err_o <= 1'b0;
      deselect_o <= 1'b0;
      unique case (state_r)
        ST_UNSYNC: begin
          // sync on the empty cell pattern
          if (rx_rise && shreg_nxt == EMPTY_CELL) begin
            state_r <= ST_HUNT;
          end
        end
        ST_HUNT: begin
          if (cell_rdy_r) begin
            if (!shreg_r[MARK_POS]) begin
              state_r <= ST_UNSYNC; // marker lost: cell framing is wrong
            end else if (cell_id == ID_ADDR) begin
              // address and strobe to all adapters together
              sel_addr_o <= shreg_r[DATA_W-1:0];
              sel_strobe_o <= 1'b1;
              selected_o <= 1'b1;
              cell_cnt_r <= 5'h1;
              state_r <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          if (cell_rdy_r) begin
            if (cell_id == ID_CHKSUM) begin
              // no byte for the checksum cell, report the compare
              chk_ok_o <= (shreg_r[DATA_W-1:0] == frame_crc);
              chk_err_o <= (shreg_r[DATA_W-1:0] != frame_crc);
              state_r <= ST_DESEL;
            end else if (cell_cnt_r == MAX_CELLS) begin
              ovr_err_o <= 1'b1;
              state_r <= ST_DESEL;
            end else begin
              // byte is the cell minus its marker
              byte_o <= shreg_r[BYTE_W-1:0];
              byte_valid_o <= 1'b1;
              cell_cnt_r <= cell_cnt_r + 5'h1;
            end
          end
        end
        ST_DESEL: begin
          // result went out last cycle; now release and hunt
          deselect_o <= 1'b1;
          selected_o <= 1'b0;
          state_r <= ST_HUNT;
        end
      endcase
    end
  end

  assign synced_o = (state_r != ST_UNSYNC);

  // input side guard: the seventeenth byte disconnects and closes with the checksum
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      in_cnt_r <= '0;
      in_disconnect_o <= 1'b0;
      in_append_crc_o <= 1'b0;
    end else begin
      in_disconnect_o <= 1'b0;
      in_append_crc_o <= 1'b0;
      if (!in_sel_i) begin
        in_cnt_r <= '0;
      end else if (in_byte_valid_i) begin
        if (in_cnt_r == MAX_CELLS) begin
          in_disconnect_o <= 1'b1;
          in_append_crc_o <= 1'b1;
        end else begin
          in_cnt_r <= in_cnt_r + 5'h1;
        end
      end
    end
  end

  property p_fwd;
    @(posedge mclk_i) disable iff (rst_i) rx_rise |=> loop_data_o == $past(dat_s2_r);
  endproperty
  a_fwd: assert property (p_fwd) else $error("bit not forwarded");

  property p_regen;
    @(posedge mclk_i) disable iff (rst_i) rx_rise |=> (!loop_clk_o) [*4] ##1 loop_clk_o;
  endproperty
  a_regen: assert property (p_regen) else $error("regenerated clock shape wrong");

  property p_sync;
    @(posedge mclk_i) disable iff (rst_i)
      (state_r == ST_UNSYNC && rx_rise && shreg_nxt == EMPTY_CELL) |=> synced_o;
  endproperty
  a_sync: assert property (p_sync) else $error("empty cell did not sync");

  property p_strobe;
    @(posedge mclk_i) disable iff (rst_i) sel_strobe_o |-> selected_o && $past(cell_id) == ID_ADDR;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without address cell");

  property p_byte;
    @(posedge mclk_i) disable iff (rst_i)
      byte_valid_o |-> selected_o && byte_o == $past(shreg_r[BYTE_W-1:0]) && $past(cell_id) != ID_CHKSUM;
  endproperty
  a_byte: assert property (p_byte) else $error("byte does not match cell");

  property p_result;
    @(posedge mclk_i) disable iff (rst_i)
      (chk_ok_o || chk_err_o) |-> selected_o && !(chk_ok_o && chk_err_o) && !byte_valid_o;
  endproperty
  a_result: assert property (p_result) else $error("bad checksum report");

  property p_err_first;
    @(posedge mclk_i) disable iff (rst_i) (chk_err_o || ovr_err_o) |=> deselect_o ##1 !selected_o;
  endproperty
  a_err_first: assert property (p_err_first) else $error("error not ahead of deselect");

  property p_rehunt;
    @(posedge mclk_i) disable iff (rst_i) deselect_o |-> state_r == ST_HUNT && !selected_o;
  endproperty
  a_rehunt: assert property (p_rehunt) else $error("no return to hunting");

  property p_ovr;
    @(posedge mclk_i) disable iff (rst_i) ovr_err_o |-> cell_cnt_r == MAX_CELLS;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun at wrong count");

  property p_reset;
    @(posedge mclk_i) rst_i |=> !synced_o && !selected_o && frame_crc == CRC_INIT;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_in_ovr;
    @(posedge mclk_i) disable iff (rst_i) in_disconnect_o |-> in_append_crc_o && $past(in_cnt_r) == MAX_CELLS;
  endproperty
  a_in_ovr: assert property (p_in_ovr) else $error("input overrun wrong");

  c_sync: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(synced_o));
  c_ok: cover property (@(posedge mclk_i) disable iff (rst_i) chk_ok_o);
  c_err: cover property (@(posedge mclk_i) disable iff (rst_i) chk_err_o);
  c_ovr: cover property (@(posedge mclk_i) disable iff (rst_i) ovr_err_o);
endmodule // lmo_output_section
`default_nettype wire

// >>> verification/lmo_adapter_model.sv
/*
  lmo_adapter_model: behavioural line adapter hanging on the shared select bus.
  Assumes every bus signal is launched from mclk_i by the output section.
*/
`timescale 1ns/1ps
`default_nettype none
module lmo_adapter_model
  import lmo_pkg::*;
#(
  parameter logic [DATA_W-1:0] OWN_ADDR = 8'h00
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // select bus from the section
  input wire logic [DATA_W-1:0] sel_addr_i,
  input wire logic sel_strobe_i,
  input wire logic [BYTE_W-1:0] byte_i,
  input wire logic byte_valid_i,
  input wire logic chk_ok_i,
  input wire logic chk_err_i,
  input wire logic ovr_err_i,
  input wire logic deselect_i,
  // observed state
  output logic att_o,
  output logic [4:0] cnt_o,
  output logic [BYTE_W-1:0] last_o,
  output logic [2:0] res_o,
  output logic early_o
);
  // attach on own address, take bytes until let go
  // early_o records whether a result had already landed when the disconnect came
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      att_o <= 1'b0;
      cnt_o <= 5'h00;
      last_o <= '0;
      res_o <= 3'h0;
      early_o <= 1'b0;
    end else if (sel_strobe_i && sel_addr_i == OWN_ADDR) begin
      att_o <= 1'b1;
      cnt_o <= 5'h00;
      res_o <= 3'h0;
      early_o <= 1'b0;
    end else if (att_o) begin
      if (byte_valid_i) begin
        cnt_o <= cnt_o + 5'h01;
        last_o <= byte_i;
      end
      if (chk_ok_i || chk_err_i || ovr_err_i) begin
        res_o <= {ovr_err_i, chk_err_i, chk_ok_i};
      end
      if (deselect_i) begin
        att_o <= 1'b0;
        early_o <= |res_o;
      end
    end
  end
endmodule // lmo_adapter_model
`default_nettype wire

// >>> verification/tb.sv
/*
  tb: self-checking bench for the loop multiplexer output section.
  Assumes a 100 MHz mclk_i and a 125 ns loop bit time driven by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lmo_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic loop_clk_i = 1'b1;
  logic loop_data_i = 1'b0;
  logic in_sel_i = 1'b0;
  logic in_byte_valid_i = 1'b0;
  logic loop_clk_o, loop_data_o, sel_strobe_o, selected_o, byte_valid_o;
  logic chk_ok_o, chk_err_o, ovr_err_o, deselect_o, synced_o, in_disconnect_o, in_append_crc_o;
  logic [DATA_W-1:0] sel_addr_o;
  logic [BYTE_W-1:0] byte_o, a_last;
  logic a_att, b_att, a_early, b_early;
  logic [4:0] a_cnt;
  logic [2:0] a_res, b_res;
  logic [DATA_W-1:0] crc;
  logic clk_prev = 1'b1;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int lo = 0;
  bit ph = 1'b0;
  bit sent_q[$];

  lmo_output_section i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .loop_clk_i(loop_clk_i), .loop_data_i(loop_data_i),
    .loop_clk_o(loop_clk_o), .loop_data_o(loop_data_o), .sel_addr_o(sel_addr_o), .sel_strobe_o(sel_strobe_o),
    .selected_o(selected_o), .byte_o(byte_o), .byte_valid_o(byte_valid_o), .chk_ok_o(chk_ok_o),
    .chk_err_o(chk_err_o), .ovr_err_o(ovr_err_o), .deselect_o(deselect_o), .synced_o(synced_o),
    .in_sel_i(in_sel_i), .in_byte_valid_i(in_byte_valid_i), .in_disconnect_o(in_disconnect_o),
    .in_append_crc_o(in_append_crc_o));

  // two adapters with distinct addresses share the bus
  lmo_adapter_model #(.OWN_ADDR(8'h5a)) i_ad_a (.mclk_i(mclk_i), .rst_i(rst_i), .sel_addr_i(sel_addr_o),
    .sel_strobe_i(sel_strobe_o), .byte_i(byte_o), .byte_valid_i(byte_valid_o), .chk_ok_i(chk_ok_o),
    .chk_err_i(chk_err_o), .ovr_err_i(ovr_err_o), .deselect_i(deselect_o), .att_o(a_att), .cnt_o(a_cnt),
    .last_o(a_last), .res_o(a_res), .early_o(a_early));
  lmo_adapter_model #(.OWN_ADDR(8'ha5)) i_ad_b (.mclk_i(mclk_i), .rst_i(rst_i), .sel_addr_i(sel_addr_o),
    .sel_strobe_i(sel_strobe_o), .byte_i(byte_o), .byte_valid_i(byte_valid_o), .chk_ok_i(chk_ok_o),
    .chk_err_i(chk_err_o), .ovr_err_i(ovr_err_o), .deselect_i(deselect_o), .att_o(b_att), .cnt_o(),
    .last_o(), .res_o(b_res), .early_o(b_early));

  // core clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [DATA_W-1:0] crc_step(input logic [DATA_W-1:0] c, input logic b);
    return {c[6:0], 1'b0} ^ ((b ^ c[7]) ? CRC_POLY : 8'h00);
  endfunction

  // one bit, 12 or 13 cycles alternately; released data shows the inverse
  task automatic send_bit(input logic b);
    @(negedge mclk_i);
    loop_data_i = b;
    loop_clk_i = 1'b0;
    sent_q.push_back(b);
    repeat (6) @(negedge mclk_i);
    loop_clk_i = 1'b1;
    repeat (5 + int'(ph)) @(negedge mclk_i);
    ph = ~ph;
    loop_data_i = ~b;
  endtask

  task automatic send_cell(input logic [CELL_W-1:0] c, input bit acc);
    for (int i = CELL_W - 1; i >= 0; i--) begin
      if (acc) crc = crc_step(crc, c[i]);
      send_bit(c[i]);
    end
  endtask

  // address, n data cells (fourth one null), checksum cell optionally corrupted
  task automatic send_frame(input logic [7:0] addr, input int n, input bit bad);
    logic [CELL_W-1:0] ck;
    crc = CRC_INIT;
    send_cell({1'b1, ID_ADDR, addr}, 1'b1);
    for (int i = 0; i < n; i++) send_cell({1'b1, (i == 3) ? ID_NULL : ID_DATA, 8'(i * 17)}, 1'b1);
    ck = {1'b1, ID_CHKSUM, 8'h00};
    for (int i = 11; i >= 8; i--) crc = crc_step(crc, ck[i]);
    send_cell({ck[11:8], crc ^ {7'h00, bad}}, 1'b0);
    repeat (4) @(negedge mclk_i);
  endtask

  // forwarded bits and regenerated clock low time, seen at each outgoing rise
  always @(posedge mclk_i) begin
    if (!rst_i && loop_clk_o === 1'b0) begin
      lo++;
    end else if (!rst_i && clk_prev === 1'b0) begin
      check(lo[15:0], 16'(CLK_LO_CYC));
      check(16'(loop_data_o), 16'(sent_q.pop_front()));
      lo = 0;
    end
    clk_prev = loop_clk_o;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic t_reset();
    check(16'({loop_clk_o, loop_data_o, selected_o, synced_o, sel_strobe_o, byte_valid_o}), 16'h0020);
  endtask

  // sync, hunt past a data cell, lose sync on a bad marker, sync again
  task automatic t_sync();
    send_cell(12'h3c3, 1'b0);
    check(16'(synced_o), 16'h0000);
    send_cell(EMPTY_CELL, 1'b0);
    check(16'(synced_o), 16'h0001);
    send_cell({1'b1, ID_DATA, 8'h5a}, 1'b0);
    check(16'({selected_o, a_att}), 16'h0000);
    send_cell(12'h05a, 1'b0);
    check(16'(synced_o), 16'h0000);
    send_cell(EMPTY_CELL, 1'b0);
    check(16'(synced_o), 16'h0001);
  endtask

  task automatic t_frames();
    send_frame(8'h5a, 5, 1'b0);
    check(16'(a_cnt), 16'h0005);
    check(16'(a_last), 16'({ID_DATA, 8'h44}));
    check(16'(a_res), 16'h0001);
    check(16'({a_att, selected_o, b_att, b_res}), 16'h0000);
    check(16'(sel_addr_o), 16'h005a);
    send_frame(8'ha5, 0, 1'b1);
    check(16'(b_res), 16'h0002);
    check(16'(b_early), 16'h0001);
    check(16'(a_res), 16'h0001);
    send_frame(8'h5a, 16, 1'b0);
    check(16'(a_res), 16'h0004);
    check(16'({a_att, a_cnt}), 16'h000f);
    send_frame(8'h5a, 1, 1'b0);
    check(16'(a_res), 16'h0001);
  endtask

  task automatic t_guard();
    @(negedge mclk_i);
    in_sel_i = 1'b1;
    // the pulse stands for the one cycle after the taking edge, so look then
    for (int i = 0; i < 17; i++) begin
      @(negedge mclk_i);
      in_byte_valid_i = 1'b1;
      @(negedge mclk_i);
      in_byte_valid_i = 1'b0;
      check(16'({in_disconnect_o, in_append_crc_o}), (i == 16) ? 16'h0003 : 16'h0000);
    end
    @(negedge mclk_i);
    check(16'({in_disconnect_o, in_append_crc_o}), 16'h0000);
    in_sel_i = 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    t_reset();
    t_sync();
    t_frames();
    t_guard();
    final_report();
  end
endmodule // tb
`default_nettype wire
